/* addr_conv_pkg.sv */
// Operation
// - short value 1 to 1,933,312 gets 32,768 added, one 21-bit word.
// - values 2,101,249 to 1,075,843,072 are long set 1-2, two words.
// - sets 1-2/1-3/1-4 word one is ((value-2,068,481) mod 32768)+1.
// - set 1-2 word two is 2,097,151 minus quotient, ones complement.
// - values 1,075,843,073 to 3,223,326,720 are sets 1-3/1-4, same word one.
// - sets 1-3/1-4 word two is quotient plus 1,933,312.
// - values 3,223,326,721 to 4,297,068,542 are long set 2-3.
// - set 2-3 word one is ((value-2,068,479) mod 32,768)+2,064,383.
// - set 2-3 word two is quotient plus 1,867,776.
// - reverse of short word subtracts 32,768.
// - reverse set 1-2 pair: complement word two, times 32,768, add 2,068,480 and word one.
// - letters A-D are single-phase with subtract offsets 0-3.
// - E-H any-phase, I-L all-phase, offsets 0-3 in letter order.
// - U-X single-phase with phases 0-3, Y any-phase, Z all-phase, non-standard.
// - 2,101,249-102,101,250 uncoordinated; up to 402,101,250 country-coordinated.
// - values outside listed assignment ranges flagged undefined/illegal, class CL_ILLEGAL.
// - words 000000 and 1FFFFF are idle words, treated as illegal.
package addr_conv_pkg;
    localparam int VAL_W  = 33;
    localparam int WORD_W = 21;
    localparam int SHIFT  = 15;
    localparam logic [VAL_W-1:0] SHORT_OFS   = 33'h0_0000_8000;
    localparam logic [VAL_W-1:0] SHORT_LIM   = 33'h0_001E_FFFF;
    localparam logic [VAL_W-1:0] SHORT_MAX   = 33'h0_001D_8000;
    localparam logic [VAL_W-1:0] RSV_LO      = 33'h0_001E_8001;
    localparam logic [VAL_W-1:0] LONG12_LO   = 33'h0_0020_1001;
    localparam logic [VAL_W-1:0] UNCOORD_HI  = 33'h0_0615_F102;
    localparam logic [VAL_W-1:0] COUNTRY_HI  = 33'h0_17F7_9402;
    localparam logic [VAL_W-1:0] LONG12_HI   = 33'h0_4020_1000;
    localparam logic [VAL_W-1:0] LONG14_HI   = 33'h0_C020_1000;
    localparam logic [VAL_W-1:0] LONG23_HI   = 33'h1_0020_0FFE;
    localparam logic [VAL_W-1:0] BASE_1X     = 33'h0_001F_9001;
    localparam logic [VAL_W-1:0] BASE_23     = 33'h0_001F_8FFF;
    localparam logic [VAL_W-1:0] REV_BASE_12 = 33'h0_001F_9000;
    localparam logic [WORD_W-1:0] W2_OFS_1X  = 21'h1D_8000;
    localparam logic [WORD_W-1:0] W1_OFS_23  = 21'h1F_7FFF;
    localparam logic [WORD_W-1:0] W2_OFS_23  = 21'h1C_8000;
    localparam logic [WORD_W-1:0] IDLE_ZERO  = 21'h00_0000;
    localparam logic [WORD_W-1:0] IDLE_ONES  = 21'h1F_FFFF;
    // letter codes, 0..25 for A..Z
    localparam logic [4:0] LET_A = 5'h00;
    localparam logic [4:0] LET_E = 5'h04;
    localparam logic [4:0] LET_I = 5'h08;
    localparam logic [4:0] LET_L = 5'h0B;
    localparam logic [4:0] LET_U = 5'h14;
    localparam logic [4:0] LET_X = 5'h17;
    localparam logic [4:0] LET_Y = 5'h18;
    localparam logic [4:0] LET_Z = 5'h19;
    typedef enum logic [1:0] {
        PH_SINGLE = 2'h0,
        PH_ANY    = 2'h1,
        PH_ALL    = 2'h2,
        PH_NONE   = 2'h3
    } phase_kind_e;
    typedef enum logic [2:0] {
        CL_ILLEGAL = 3'h0,
        CL_SHORT   = 3'h1,
        CL_UNCOORD = 3'h2,
        CL_COUNTRY = 3'h3,
        CL_GLOBAL  = 3'h4,
        CL_RESERVE = 3'h5
    } class_e;
endpackage

/* type_letter_decoder.sv */
`timescale 1ns/1ps
module type_letter_decoder
    import addr_conv_pkg::*;
(
    input  wire logic [4:0] i_letter,     // 0=A .. 25=Z
    output phase_kind_e     o_kind,       // device phase type
    output logic [1:0]      o_offset,     // subtract offset
    output logic [1:0]      o_phase,      // explicit phase
    output logic            o_standard,   // standard embedding rules
    output logic            o_valid       // letter is defined
);
    wire in_std  = (i_letter <= LET_L);
    wire in_unit = (i_letter >= LET_U) && (i_letter <= LET_X);
    wire [4:0] rel_u = i_letter - LET_U;

    assign o_standard = in_std;
    assign o_valid    = in_std || (i_letter >= LET_U && i_letter <= LET_Z);
    assign o_offset   = in_std ? i_letter[1:0] : 2'h0;
    assign o_phase    = in_unit ? rel_u[1:0] : 2'h0;
    assign o_kind = (i_letter < LET_E) ? PH_SINGLE :
                    (i_letter < LET_I) ? PH_ANY :
                    in_std             ? PH_ALL :
                    in_unit            ? PH_SINGLE :
                    (i_letter == LET_Y) ? PH_ANY :
                    (i_letter == LET_Z) ? PH_ALL : PH_NONE;
endmodule

/* pager_address_converter.sv */
`timescale 1ns/1ps
module pager_address_converter
    import addr_conv_pkg::*;
(
    input  wire logic              i_core_clk,   // core clock
    input  wire logic              i_rst_n,      // async reset, low
    input  wire logic              i_ce,         // clock enable
    input  wire logic              i_valid,      // request strobe
    input  wire logic              i_reverse,    // 1: words to value
    input  wire logic [VAL_W-1:0]  i_value,      // pager_address_code
    input  wire logic [WORD_W-1:0] i_word1,      // reverse word one
    input  wire logic [WORD_W-1:0] i_word2,      // reverse word two
    input  wire logic              i_long,       // reverse: two words
    input  wire logic [4:0]        i_letter,     // type letter 0=A
    output logic                   o_valid,      // answer strobe
    output logic [WORD_W-1:0]      o_word1,      // first word
    output logic [WORD_W-1:0]      o_word2,      // second word
    output logic [1:0]             o_count,      // words produced
    output logic                   o_illegal,    // undefined/illegal
    output logic [VAL_W-1:0]       o_value,      // reverse result
    output logic [2:0]             o_class,      // class_e code
    output logic [1:0]             o_kind,       // phase_kind_e code
    output logic [1:0]             o_offset,     // subtract offset
    output logic [1:0]             o_phase,      // explicit phase
    output logic                   o_standard,   // standard rules
    output logic [VAL_W-1:0]       o_adj_value   // value minus offset
);
    // forward classification
    wire is_short  = (i_value != '0) && (i_value <= SHORT_MAX);
    wire is_l12    = (i_value >= LONG12_LO) && (i_value <= LONG12_HI);
    wire is_l1x    = (i_value > LONG12_HI) && (i_value <= LONG14_HI);
    wire is_l23    = (i_value > LONG14_HI) && (i_value <= LONG23_HI);

    // shared offset arithmetic; divide by 32768 is a shift
    wire [VAL_W-1:0] diff_1x = i_value - BASE_1X;
    wire [VAL_W-1:0] diff_23 = i_value - BASE_23;
    wire [WORD_W-1:0] quo_1x = WORD_W'(diff_1x >> SHIFT);
    wire [WORD_W-1:0] quo_23 = WORD_W'(diff_23 >> SHIFT);
    wire [WORD_W-1:0] rem_1x = {6'h00, diff_1x[SHIFT-1:0]};
    wire [WORD_W-1:0] rem_23 = {6'h00, diff_23[SHIFT-1:0]};

    wire [WORD_W-1:0] fw_short = WORD_W'(i_value + SHORT_OFS);
    wire [WORD_W-1:0] fw_l1_w1 = rem_1x + 21'h00_0001;
    wire [WORD_W-1:0] fw_l12_w2 = ~quo_1x;
    wire [WORD_W-1:0] fw_l1x_w2 = quo_1x + W2_OFS_1X;
    wire [WORD_W-1:0] fw_l23_w1 = rem_23 + W1_OFS_23;
    wire [WORD_W-1:0] fw_l23_w2 = quo_23 + W2_OFS_23;

    wire [WORD_W-1:0] fw_w1 = is_l23 ? fw_l23_w1 :
                              (is_l12 || is_l1x) ? fw_l1_w1 : fw_short;
    wire [WORD_W-1:0] fw_w2 = is_l23 ? fw_l23_w2 :
                              is_l1x ? fw_l1x_w2 :
                              is_l12 ? fw_l12_w2 : IDLE_ZERO;
    wire fw_long = is_l12 || is_l1x || is_l23;
    // idle words never leave as valid addresses
    wire fw_idle = (fw_w1 == IDLE_ZERO) || (fw_w1 == IDLE_ONES)
                || (fw_long && (fw_w2 == IDLE_ZERO || fw_w2 == IDLE_ONES));
    wire fw_ok = (is_short || fw_long) && !fw_idle;

    // set 1-2 by coordination band, global above 402,101,250; 1-3/1-4 global; 2-3 reserved tail
    wire [2:0] fw_class = !fw_ok       ? CL_ILLEGAL :
                          is_short     ? CL_SHORT :
                          (is_l12 && i_value <= UNCOORD_HI) ? CL_UNCOORD :
                          (is_l12 && i_value <= COUNTRY_HI) ? CL_COUNTRY :
                          (is_l12 || is_l1x) ? CL_GLOBAL : CL_RESERVE;

    // reverse conversion
    wire rv_w1_idle = (i_word1 == IDLE_ZERO) || (i_word1 == IDLE_ONES);
    wire rv_w2_idle = (i_word2 == IDLE_ZERO) || (i_word2 == IDLE_ONES);
    wire [VAL_W-1:0] rv_short = {12'h000, i_word1} - SHORT_OFS;
    wire [WORD_W-1:0] rv_cmp  = ~i_word2;
    wire [VAL_W-1:0] rv_long  = ({12'h000, rv_cmp} << SHIFT)
                              + REV_BASE_12 + {12'h000, i_word1};
    wire rv_short_bad = (i_word1 <= 21'h00_8000);
    wire rv_bad = rv_w1_idle || (i_long && rv_w2_idle)
               || (!i_long && rv_short_bad);

    // letter decode
    phase_kind_e let_kind;
    logic [1:0]  let_offset;
    logic [1:0]  let_phase;
    logic        let_std;
    logic        let_ok;
    type_letter_decoder u_letter (
        .i_letter   (i_letter),
        .o_kind     (let_kind),
        .o_offset   (let_offset),
        .o_phase    (let_phase),
        .o_standard (let_std),
        .o_valid    (let_ok)
    );
    wire [VAL_W-1:0] adj = i_value - {31'h0000_0000, let_offset};

    // registered answer, one cycle after the request
    logic                valid_q;
    logic [WORD_W-1:0]   word1_q;
    logic [WORD_W-1:0]   word2_q;
    logic [1:0]          count_q;
    logic                illegal_q;
    logic [VAL_W-1:0]    value_q;
    logic [2:0]          class_q;
    logic [1:0]          kind_q;
    logic [1:0]          offset_q;
    logic [1:0]          phase_q;
    logic                std_q;
    logic [VAL_W-1:0]    adj_q;

    wire take = i_ce && i_valid;
    wire [1:0] cnt_d = i_reverse ? (i_long ? 2'h2 : 2'h1)
                     : (!fw_ok ? 2'h0 : fw_long ? 2'h2 : 2'h1);
    wire ill_d = i_reverse ? rv_bad : (!fw_ok || !let_ok);

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            valid_q <= 1'b0;
        end else if (i_ce) begin
            valid_q <= i_valid;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            word1_q   <= '0;
            word2_q   <= '0;
            count_q   <= 2'h0;
            illegal_q <= 1'b0;
            value_q   <= '0;
            class_q   <= 3'h0;
        end else if (take) begin
            word1_q   <= i_reverse ? i_word1 : (fw_ok ? fw_w1 : IDLE_ZERO);
            word2_q   <= i_reverse ? i_word2 : (fw_ok ? fw_w2 : IDLE_ZERO);
            count_q   <= cnt_d;
            illegal_q <= ill_d;
            value_q   <= i_reverse ? (i_long ? rv_long : rv_short) : i_value;
            class_q   <= i_reverse ? 3'h0 : fw_class;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            kind_q   <= 2'h3;
            offset_q <= 2'h0;
            phase_q  <= 2'h0;
            std_q    <= 1'b0;
            adj_q    <= '0;
        end else if (take) begin
            kind_q   <= let_kind;
            offset_q <= let_offset;
            phase_q  <= let_phase;
            std_q    <= let_std;
            adj_q    <= let_std ? adj : i_value;
        end
    end

    assign o_valid     = valid_q;
    assign o_word1     = word1_q;
    assign o_word2     = word2_q;
    assign o_count     = count_q;
    assign o_illegal   = illegal_q;
    assign o_value     = value_q;
    assign o_class     = class_q;
    assign o_kind      = kind_q;
    assign o_offset    = offset_q;
    assign o_phase     = phase_q;
    assign o_standard  = std_q;
    assign o_adj_value = adj_q;
endmodule

/* conv_props.sv */
`timescale 1ns/1ps
module conv_props
    import addr_conv_pkg::*;
(
    input wire logic              i_core_clk, // clock
    input wire logic              i_rst_n,    // reset
    input wire logic              i_ce,       // enable
    input wire logic              i_valid,    // request
    input wire logic              i_reverse,  // direction
    input wire logic              i_long,     // pair
    input wire logic [VAL_W-1:0]  i_value,    // value
    input wire logic [WORD_W-1:0] i_word1,    // word one
    input wire logic [WORD_W-1:0] i_word2,    // word two
    input wire logic [4:0]        i_letter,   // letter
    input wire logic              o_valid,    // answer
    input wire logic [WORD_W-1:0] o_word1,    // word one
    input wire logic [WORD_W-1:0] o_word2,    // word two
    input wire logic [1:0]        o_count,    // count
    input wire logic              o_illegal,  // illegal
    input wire logic [VAL_W-1:0]  o_value,    // value
    input wire logic [2:0]        o_class,    // class
    input wire logic [1:0]        o_kind,     // kind
    input wire logic [1:0]        o_offset    // offset
);
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_n);
    wire logic [VAL_W-1:0]  d1 = i_value - BASE_1X;
    wire logic [VAL_W-1:0]  d2 = i_value - BASE_23;
    wire logic [WORD_W-1:0] q1 = WORD_W'(d1 >> SHIFT);
    wire logic [WORD_W-1:0] q2 = WORD_W'(d2 >> SHIFT);
    wire logic [WORD_W-1:0] e_sh = WORD_W'(i_value + SHORT_OFS);
    wire logic [WORD_W-1:0] e_w1 = WORD_W'(d1[SHIFT-1:0]) + 21'h00_0001;
    wire logic [WORD_W-1:0] e_a23 = WORD_W'(d2[SHIFT-1:0]) + W1_OFS_23;
    wire logic [VAL_W-1:0]  e_rs = VAL_W'(i_word1) - SHORT_OFS;
    wire logic [VAL_W-1:0]  e_rl = (VAL_W'(~i_word2) << SHIFT)
                                   + REV_BASE_12 + VAL_W'(i_word1);
    sequence s_fwd(lo, hi);
        i_ce && i_valid && !i_reverse && i_letter == LET_A
            && i_value >= lo && i_value <= hi;
    endsequence
    sequence s_rev(lg);
        i_ce && i_valid && i_reverse && i_long == lg && i_word1 != IDLE_ZERO;
    endsequence
    property p_answer;
        i_ce && i_valid |=> o_valid ##1 !o_valid || $past(i_valid);
    endproperty
    a_answer: assert property (p_answer) else $error("answer strobe");
    property p_short;
        s_fwd(33'h1, SHORT_MAX) |=> o_word1 == $past(e_sh) && o_count == 2'h1;
    endproperty
    a_short: assert property (p_short) else $error("short word");
    property p_w12;
        s_fwd(LONG12_LO, LONG12_HI) |=> o_count == 2'h2
            && o_word1 == $past(e_w1) && o_word2 == ~$past(q1);
    endproperty
    a_w12: assert property (p_w12) else $error("set 1-2 words");
    property p_w1x;
        s_fwd(LONG12_HI + 33'h1, LONG14_HI) |=> o_word1 == $past(e_w1)
            && o_word2 == $past(q1) + W2_OFS_1X && o_class == 3'h4;
    endproperty
    a_w1x: assert property (p_w1x) else $error("set 1-3 words");
    property p_w23;
        s_fwd(LONG14_HI + 33'h1, LONG23_HI) |=> o_word1 == $past(e_a23)
            && o_word2 == $past(q2) + W2_OFS_23;
    endproperty
    a_w23: assert property (p_w23) else $error("set 2-3 words");
    property p_bad;
        s_fwd(SHORT_MAX + 33'h1, LONG12_LO - 33'h1)
            |=> o_illegal && o_count == 2'h0;
    endproperty
    a_bad: assert property (p_bad) else $error("gap not illegal");
    property p_class;
        s_fwd(LONG12_LO, COUNTRY_HI) |=> o_class ==
            ($past(i_value) > UNCOORD_HI ? 3'h3 : 3'h2);
    endproperty
    a_class: assert property (p_class) else $error("class");
    property p_rs;
        s_rev(1'b0) ##0 i_word1 > SHORT_OFS[20:0] && i_word1 != IDLE_ONES
            |=> o_value == $past(e_rs);
    endproperty
    a_rs: assert property (p_rs) else $error("reverse short");
    property p_rl;
        s_rev(1'b1) ##0 i_word2 != IDLE_ONES |=> o_value == $past(e_rl);
    endproperty
    a_rl: assert property (p_rl) else $error("reverse pair");
    property p_let;
        i_ce && i_valid && i_letter <= LET_L |=> o_kind == $past(i_letter[3:2])
            && o_offset == $past(i_letter[1:0]);
    endproperty
    a_let: assert property (p_let) else $error("letter");
    property p_hold;
        !i_ce |=> $stable(o_valid) && $stable(o_word1) && $stable(o_count);
    endproperty
    a_hold: assert property (p_hold) else $error("enable freeze");
endmodule
bind pager_address_converter conv_props i_chk (.i_core_clk, .i_rst_n,
    .i_ce, .i_valid, .i_reverse, .i_long, .i_value, .i_word1, .i_word2,
    .i_letter, .o_valid, .o_word1, .o_word2, .o_count, .o_illegal,
    .o_value, .o_class, .o_kind, .o_offset);

/* host_req_model.sv */
`timescale 1ns/1ps
module host_req_model
    import addr_conv_pkg::*;
(
    input  wire logic        i_core_clk, // clock
    output logic             o_valid,    // strobe
    output logic             o_reverse,  // direction
    output logic             o_long,     // pair
    output logic [VAL_W-1:0] o_value,    // value
    output logic [WORD_W-1:0] o_word1,   // word one
    output logic [WORD_W-1:0] o_word2,   // word two
    output logic [4:0]       o_letter    // letter
);
    initial begin
        {o_valid, o_reverse, o_long, o_value, o_word1, o_word2} = '0;
        o_letter = 5'h00;
    end
    // one-cycle strobe; data scrambled after so stale values are caught
    task automatic send(input logic r, l, input logic [VAL_W-1:0] v,
                        input logic [WORD_W-1:0] a, b, input logic [4:0] t);
        @(posedge i_core_clk);
        o_valid <= 1'b1;
        {o_reverse, o_long, o_value, o_word1, o_word2} <= {r, l, v, a, b};
        o_letter <= t;
        @(posedge i_core_clk);
        o_valid <= 1'b0;
        {o_value, o_word1, o_word2} <= ~{v, a, b};
    endtask
endmodule

/* tb.sv */
`timescale 1ns/1ps
module tb
    import addr_conv_pkg::*;
;
    logic clk = 1'b0, rst_n = 1'b0, ce = 1'b1;
    logic v_q, r_q, l_q;
    logic [VAL_W-1:0] val_q, o_value, o_adj;
    logic [WORD_W-1:0] a_q, b_q, o_word1, o_word2;
    logic [4:0] t_q;
    logic o_valid, o_illegal, o_std;
    logic [1:0] o_count, o_kind, o_offset, o_phase;
    logic [2:0] o_class;
    int n_fail = 0, cmp_count = 0;
    host_req_model i_host (.i_core_clk(clk), .o_valid(v_q), .o_reverse(r_q),
        .o_long(l_q), .o_value(val_q), .o_word1(a_q), .o_word2(b_q),
        .o_letter(t_q));
    pager_address_converter i_dut (.i_core_clk(clk), .i_rst_n(rst_n),
        .i_ce(ce), .i_valid(v_q), .i_reverse(r_q), .i_value(val_q),
        .i_word1(a_q), .i_word2(b_q), .i_long(l_q), .i_letter(t_q),
        .o_valid(o_valid), .o_word1(o_word1), .o_word2(o_word2),
        .o_count(o_count), .o_illegal(o_illegal), .o_value(o_value),
        .o_class(o_class), .o_kind(o_kind), .o_offset(o_offset),
        .o_phase(o_phase), .o_standard(o_std), .o_adj_value(o_adj));
    initial begin
        forever #5 clk = ~clk;
    end
    task automatic bad(input string m);
        n_fail++;
        $display("ERROR %0t %s", $time, m);
    endtask
    task automatic chk_w(input logic [WORD_W-1:0] g, e);
        cmp_count++;
        if (g !== e) bad($sformatf("word %h exp %h", g, e));
    endtask
    task automatic chk_v(input logic [VAL_W-1:0] g, e);
        cmp_count++;
        if (g !== e) bad($sformatf("value %0d exp %0d", g, e));
    endtask
    task automatic chk_s(input logic [2:0] g, e);
        cmp_count++;
        if (g !== e) bad($sformatf("field %0d exp %0d", g, e));
    endtask
    task automatic ans();
        int n;
        for (n = 0; n < 4; n++) begin
            #1;
            if (o_valid === 1'b1) break;
            @(posedge clk);
        end
        if (n == 4) bad("no answer");
    endtask
    task automatic fwd(input logic [VAL_W-1:0] v, input logic [4:0] t);
        i_host.send(1'b0, 1'b0, v, '0, '0, t);
        ans();
    endtask
    task automatic t_short();
        fwd(33'd1, 5'd0);
        chk_w(o_word1, 21'h00_8001);
        chk_s(3'(o_count), 3'd1);
        chk_s(o_class, 3'd1);
        fwd(33'd1933312, 5'd0);
        chk_w(o_word1, 21'h1E_0000);
    endtask
    task automatic t_long();
        longint vs[8] = '{2101249, 102101250, 102101251, 402101250,
                          402101251, 1075843073, 64'd3223326721,
                          64'd4297068542};
        logic [2:0] cs[8] = '{3'd2, 3'd2, 3'd3, 3'd3, 3'd4, 3'd4, 3'd5,
                              3'd5};
        longint d, w1, w2;
        foreach (vs[i]) begin
            d = vs[i] - 2068481;
            w1 = d % 32768 + 1;
            w2 = (vs[i] <= 1075843072) ? 2097151 - d / 32768
                                       : d / 32768 + 1933312;
            if (vs[i] > 64'd3223326720) begin
                d = vs[i] - 2068479;
                w1 = d % 32768 + 2064383;
                w2 = d / 32768 + 1867776;
            end
            fwd(VAL_W'(vs[i]), 5'd0);
            chk_w(o_word1, WORD_W'(w1));
            chk_w(o_word2, WORD_W'(w2));
            chk_s(3'(o_count), 3'd2);
            chk_s(o_class, cs[i]);
        end
    endtask
    task automatic t_illegal();
        longint vs[6] = '{0, 1933313, 1998849, 2031615, 2101248,
                          64'd4297068543};
        foreach (vs[i]) begin
            fwd(VAL_W'(vs[i]), 5'd0);
            chk_s(3'(o_illegal), 3'd1);
            chk_s(3'(o_count), 3'd0);
        end
    endtask
    task automatic t_reverse();
        i_host.send(1'b1, 1'b0, '0, 21'h00_8001, '0, 5'd0);
        ans();
        chk_v(o_value, 33'd1);
        i_host.send(1'b1, 1'b1, '0, 21'h00_0001, 21'h1F_FFFE, 5'd0);
        ans();
        chk_v(o_value, 33'd2101249);
        i_host.send(1'b1, 1'b0, '0, IDLE_ZERO, '0, 5'd0);
        ans();
        chk_s(3'(o_illegal), 3'd1);
    endtask
    task automatic t_letters();
        int k, o, p;
        for (int t = 0; t < 26; t++) begin
            k = t < 12 ? t / 4 : t > 19 && t < 24 ? 0 : t > 23 ? t - 23 : 3;
            o = t < 12 ? t % 4 : 0;
            p = t > 19 && t < 24 ? t - 20 : 0;
            fwd(33'd100, 5'(t));
            chk_s(3'(o_kind), 3'(k));
            chk_s(3'(o_offset), 3'(o));
            chk_s(3'(o_phase), 3'(p));
            chk_v(o_adj, 33'd100 - 33'(o));
            chk_s(3'(o_std), 3'(t < 12));
            chk_s(3'(o_illegal), 3'(t > 11 && t < 20));
        end
    endtask
    task automatic t_ce();
        fwd(33'd1, 5'd0);
        @(posedge clk);
        ce <= 1'b0;
        i_host.send(1'b0, 1'b0, 33'd2, '0, '0, 5'd0);
        #1;
        chk_s(3'(o_valid), 3'd0);
        chk_w(o_word1, 21'h00_8001);
        @(posedge clk);
        ce <= 1'b1;
        fwd(33'd2, 5'd0);
        chk_w(o_word1, 21'h00_8002);
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        t_short();
        t_long();
        t_illegal();
        t_reverse();
        t_letters();
        t_ce();
        wrap_up();
    end
    initial begin
        repeat (20000) @(posedge clk);
        bad("timeout");
        wrap_up();
    end
endmodule
